// >>> core/fdcpw_power_wake.sv
// How it works
// - Any reset out of either powerdown reinitialises, then interrupts later.
// - Automatic powerdown keeps the main status register at 80H.
// - Powerdown and idle flags readable in aux status B or input register.
// - Idle pin high while idle, forced low by the quiet mask.
// - Leaving rate-select powerdown resets the device and drops old status.
// - Rate-select powerdown holds host_transfer_ready set.
// - Software or hardware reset wakes from rate-select powerdown.
// - A status read in automatic powerdown starts wake-up.
// - While waking, status reads 80H until a command byte is taken.
// - No command after wake: run minimum power-up timer, then sleep again.
// - Byte during recovery is held, ready flag drops, executed once awake.
// - Byte written without status read also wakes and is held.
// - Motor enable write wakes with ready flag kept high.
// - Powerdown pin stops the oscillator in hardware.
// - Drive select bits decode one-hot; motor bits go undecoded through the same remap.
// - Remap code swaps drives: none, 0 with 1, 0 with 2.
// - Tape choice compares virtual drive number; zero never selects tape.
// - Hardware reset clears the drive control register to 00H.
// - With DMA gate set, acknowledge plus strobe acts as chip select.
`timescale 1ns/1ps
module fdcpw_power_wake
    import fdcpw_pkg::*;
#(
    parameter int MIN_PWRUP_CYC = MIN_PWRUP_CYC_DFLT
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire fdcpw_bus_t host_bus,
    input  wire logic       osc_stop_pin,
    input  wire logic       auto_pd_en,
    input  wire logic       quiet_indicator_mask,
    input  wire logic       flag_view,
    input  wire logic       core_idle,
    input  wire logic [7:0] core_msr,
    output logic      [7:0] host_data_out_ff,
    output logic            host_data_oe_ff,
    output logic            int_cs_ff,
    output logic            irq_ff,
    output logic            idle_pin_ff,
    output logic            osc_stop_ff,
    output logic            core_rst_ff,
    output logic      [7:0] cmd_byte_ff,
    output logic            cmd_valid_ff,
    output logic            auto_pd_ff,
    output logic            dsr_pd_ff,
    output fdcpw_drv_t      drv_pins_ff,
    output logic            tape_mode_ff
);

    fdcpw_bus_t   bus_s;
    logic         osc_s;
    fdcpw_state_t st_ff;
    fdcpw_state_t nxt_st;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [7:0]   drive_control_register_ff;
    logic [7:0]   tape_drive_register_ff;
    logic         held_ff;
    logic         rd_prev_ff;
    logic         wr_prev_ff;
    logic         rd_act;
    logic         wr_act;
    logic         cs_int;
    logic         dma_acc;
    logic [2:0]   acc_addr;
    logic         rd_go;
    logic         wr_go;
    logic         msr_rd;
    logic         fifo_wr;
    logic         dor_wr;
    logic         tdr_wr;
    logic         dsr_wr;
    logic         motor_wake;
    logic         sw_rst;
    logic         dsr_pd_req;
    logic         init_done;
    logic         in_pd;
    logic         idle_now;
    logic [7:0]   main_status_register;
    logic [7:0]   rd_val;
    fdcpw_drv_t   map_pins;
    logic         map_tape;

    function automatic logic hit(input logic go,
                                 input logic [2:0] a,
                                 input logic [2:0] ofs);
        return go && (a == ofs);
    endfunction : hit

    // Bus pins come from another domain; strobes need three clocks of width
    fdcpw_sync #(
        .W    ($bits(fdcpw_bus_t) + 1),
        .INIT ({BUS_IDLE, 1'b0})
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .d       ({host_bus, osc_stop_pin}),
        .q       ({bus_s, osc_s})
    );

    assign rd_act  = ~bus_s.rd_n;
    assign wr_act  = ~bus_s.wr_n;
    assign cs_int  = ~bus_s.cs_n ||
                     (drive_control_register_ff[DOR_GATE_BIT] &&
                      ~bus_s.dack_n && (rd_act || wr_act));
    assign dma_acc = bus_s.cs_n && cs_int;
    assign acc_addr = dma_acc ? OFS_FIFO : bus_s.addr;
    assign rd_go   = rd_act && !rd_prev_ff && cs_int;
    assign wr_go   = wr_act && !wr_prev_ff && cs_int;

    assign msr_rd  = hit(rd_go, acc_addr, OFS_MSR);
    assign fifo_wr = hit(wr_go, acc_addr, OFS_FIFO);
    assign dor_wr  = hit(wr_go, acc_addr, OFS_DOR);
    assign tdr_wr  = hit(wr_go, acc_addr, OFS_TDR);
    assign dsr_wr  = hit(wr_go, acc_addr, OFS_DSR);

    assign motor_wake = dor_wr && (bus_s.data[7:DOR_MOT_LSB] != 4'h0);
    assign sw_rst = (dor_wr && !bus_s.data[DOR_NRST_BIT]) ||
                    (dsr_wr && bus_s.data[DSR_SWR_BIT]);
    assign dsr_pd_req = dsr_wr && bus_s.data[DSR_PD_BIT];
    assign init_done  = (st_ff == ST_INIT) && (cnt_ff == '0);
    assign in_pd      = (st_ff == ST_AUTO_PD) || (st_ff == ST_DSR_PD);
    assign idle_now   = (st_ff == ST_AUTO_PD) ||
                        ((st_ff == ST_ACTIVE) && core_idle && !held_ff);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rd_prev_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
        end else begin
            rd_prev_ff <= rd_act;
            wr_prev_ff <= wr_act;
        end
    end

    // Power state and its shared timer
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        if (sw_rst) begin
            nxt_st  = ST_INIT;
            nxt_cnt = CNT_W'(INIT_CYC);
        end else begin
            case (st_ff)
                ST_INIT: begin
                    if (cnt_ff == '0) begin
                        nxt_st  = ST_ACTIVE;
                        nxt_cnt = CNT_W'(MIN_PWRUP_CYC);
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                ST_ACTIVE: begin
                    if (dsr_pd_req) begin
                        nxt_st = ST_DSR_PD;
                    end else if (fifo_wr || msr_rd || motor_wake ||
                                 !core_idle) begin
                        nxt_cnt = CNT_W'(MIN_PWRUP_CYC);
                    end else if (cnt_ff != '0) begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end else if (auto_pd_en) begin
                        nxt_st = ST_AUTO_PD;
                    end
                end
                ST_AUTO_PD: begin
                    if (msr_rd || fifo_wr || motor_wake) begin
                        nxt_st  = ST_WAKE;
                        nxt_cnt = CNT_W'(WAKE_CYC);
                    end
                end
                ST_WAKE: begin
                    if (cnt_ff == '0) begin
                        nxt_st  = ST_ACTIVE;
                        nxt_cnt = CNT_W'(MIN_PWRUP_CYC);
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                // Only a reset leaves this state
                ST_DSR_PD: nxt_st = ST_DSR_PD;
                default: begin
                    nxt_st  = ST_INIT;
                    nxt_cnt = CNT_W'(INIT_CYC);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_ff  <= ST_INIT;
            cnt_ff <= CNT_W'(INIT_CYC);
        end else begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // Command byte path: straight through when awake, parked while waking
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            held_ff      <= 1'b0;
            cmd_byte_ff  <= ZERO_BYTE;
            cmd_valid_ff <= 1'b0;
        end else begin
            cmd_valid_ff <= 1'b0;
            if (sw_rst) begin
                held_ff <= 1'b0;
            end else if (fifo_wr && !held_ff &&
                         (st_ff == ST_ACTIVE)) begin
                cmd_byte_ff  <= bus_s.data;
                cmd_valid_ff <= 1'b1;
            end else if (fifo_wr && !held_ff &&
                         (st_ff == ST_AUTO_PD ||
                          st_ff == ST_WAKE)) begin
                cmd_byte_ff <= bus_s.data;
                held_ff     <= 1'b1;
            end else if (held_ff && (st_ff == ST_WAKE) &&
                         (cnt_ff == '0)) begin
                cmd_valid_ff <= 1'b1;
                held_ff      <= 1'b0;
            end
        end
    end

    // Status seen by the host
    always_comb begin
        case (st_ff)
            ST_AUTO_PD: main_status_register = MSR_READY;
            ST_DSR_PD:  main_status_register = MSR_READY;
            ST_WAKE:    main_status_register =
                            held_ff ? MSR_BUSY : MSR_READY;
            ST_INIT:    main_status_register = MSR_BUSY;
            ST_ACTIVE:  main_status_register = core_msr;
            default:    main_status_register = MSR_BUSY;
        endcase
    end

    always_comb begin
        rd_val = ZERO_BYTE;
        case (acc_addr)
            OFS_SRB: if (!flag_view) begin
                rd_val[SRB_PD_BIT]   = in_pd;
                rd_val[SRB_IDLE_BIT] = idle_now;
            end
            OFS_DIR: if (flag_view) begin
                rd_val[DIR_PD_BIT]   = in_pd;
                rd_val[DIR_IDLE_BIT] = idle_now;
            end
            OFS_DOR: rd_val = drive_control_register_ff;
            OFS_TDR: rd_val = tape_drive_register_ff;
            OFS_MSR: rd_val = main_status_register;
            default: rd_val = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            host_data_out_ff <= ZERO_BYTE;
            host_data_oe_ff  <= 1'b0;
            int_cs_ff        <= 1'b0;
        end else begin
            if (rd_go) begin
                host_data_out_ff <= rd_val;
            end
            // Drive lags the strobe by the synchroniser depth plus this register
            host_data_oe_ff <= rd_act && cs_int;
            int_cs_ff       <= cs_int;
        end
    end

    // Software-written registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            drive_control_register_ff <= DOR_RST;
            tape_drive_register_ff    <= TDR_RST;
        end else begin
            if (dor_wr) begin
                drive_control_register_ff <= bus_s.data;
            end
            if (tdr_wr) begin
                tape_drive_register_ff <= bus_s.data;
            end
        end
    end

    fdcpw_drive_map u_map (
        .drv_num               (drive_control_register_ff[DOR_SEL_LSB +: 2]),
        .virtual_motor_enables (drive_control_register_ff[DOR_MOT_LSB +: 4]),
        .startup_drive_remap   (tape_drive_register_ff[TDR_BOOT_LSB +: 2]),
        .tape_unit_choice      (tape_drive_register_ff[TDR_TAPE_LSB +: 2]),
        .pins                  (map_pins),
        .tape_mode             (map_tape)
    );

    // Interrupt raised once initialisation has run; a command byte clears it
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_ff <= 1'b0;
        end else if (init_done) begin
            irq_ff <= 1'b1;
        end else if (fifo_wr || (st_ff == ST_INIT)) begin
            irq_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            core_rst_ff  <= 1'b1;
            idle_pin_ff  <= 1'b0;
            osc_stop_ff  <= 1'b0;
            auto_pd_ff   <= 1'b0;
            dsr_pd_ff    <= 1'b0;
            drv_pins_ff  <= '0;
            tape_mode_ff <= 1'b0;
        end else begin
            core_rst_ff  <= (nxt_st == ST_INIT);
            idle_pin_ff  <= idle_now && !quiet_indicator_mask;
            osc_stop_ff  <= osc_s;
            auto_pd_ff   <= (nxt_st == ST_AUTO_PD);
            dsr_pd_ff    <= (nxt_st == ST_DSR_PD);
            drv_pins_ff  <= map_pins;
            tape_mode_ff <= map_tape;
        end
    end

endmodule : fdcpw_power_wake

// >>> core/fdcpw_pkg.sv
package fdcpw_pkg;

    // Clock rate used to turn times into cycle counts
    localparam int CLK_MHZ = 125;

    // Host-visible register offsets; rate-select write shares the status read
    localparam logic [2:0] OFS_SRB  = 3'h1;
    localparam logic [2:0] OFS_DOR  = 3'h2;
    localparam logic [2:0] OFS_TDR  = 3'h3;
    localparam logic [2:0] OFS_MSR  = 3'h4;
    localparam logic [2:0] OFS_DSR  = 3'h4;
    localparam logic [2:0] OFS_FIFO = 3'h5;
    localparam logic [2:0] OFS_DIR  = 3'h7;

    // Reset and fixed register values
    localparam logic [7:0] MSR_READY = 8'h80;
    localparam logic [7:0] MSR_BUSY  = 8'h00;
    localparam logic [7:0] DOR_RST   = 8'h00;
    localparam logic [7:0] TDR_RST   = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Field positions
    localparam int DOR_SEL_LSB  = 0;
    localparam int DOR_NRST_BIT = 2;
    localparam int DOR_GATE_BIT = 3;
    localparam int DOR_MOT_LSB  = 4;
    localparam int TDR_TAPE_LSB = 0;
    localparam int TDR_BOOT_LSB = 2;
    localparam int DSR_PD_BIT   = 6;
    localparam int DSR_SWR_BIT  = 7;
    localparam int SRB_PD_BIT   = 7;
    localparam int SRB_IDLE_BIT = 6;
    localparam int DIR_PD_BIT   = 1;
    localparam int DIR_IDLE_BIT = 2;

    // Drive remap codes
    localparam logic [1:0] BOOT_IDENT  = 2'h0;
    localparam logic [1:0] BOOT_SWAP01 = 2'h1;
    localparam logic [1:0] BOOT_SWAP02 = 2'h2;
    localparam logic [1:0] TAPE_NONE   = 2'h0;

    // Timing
    localparam int WAKE_NS      = 10000;
    localparam int INIT_IRQ_NS  = 2000;
    localparam int MIN_PWRUP_US = 500;
    localparam int WAKE_CYC     = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYC     = (INIT_IRQ_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_PWRUP_CYC_DFLT = MIN_PWRUP_US * CLK_MHZ;
    localparam int CNT_W        = 17;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       dack_n;
        logic [2:0] addr;
        logic [7:0] data;
    } fdcpw_bus_t;

    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] mot;
    } fdcpw_drv_t;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_ACTIVE,
        ST_AUTO_PD,
        ST_WAKE,
        ST_DSR_PD
    } fdcpw_state_t;

    localparam fdcpw_bus_t BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1,
        wr_n: 1'b1, dack_n: 1'b1, addr: 3'h0, data: 8'h00};

endpackage : fdcpw_pkg

// >>> core/fdcpw_sync.sv
`timescale 1ns/1ps
module fdcpw_sync
    import fdcpw_pkg::*;
#(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            meta_ff <= INIT;
            q_ff    <= INIT;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule : fdcpw_sync

// >>> core/fdcpw_drive_map.sv
`timescale 1ns/1ps
module fdcpw_drive_map
    import fdcpw_pkg::*;
(
    input  wire logic [1:0] drv_num,
    input  wire logic [3:0] virtual_motor_enables,
    input  wire logic [1:0] startup_drive_remap,
    input  wire logic [1:0] tape_unit_choice,
    output fdcpw_drv_t      pins,
    output logic            tape_mode
);

    logic [3:0] virtual_drive_selects;

    // Physical index that carries a given virtual drive
    function automatic logic [1:0] phys_of(input logic [1:0] v,
                                           input logic [1:0] code);
        logic [1:0] p;
        p = v;
        case (code)
            BOOT_SWAP01: if (v < 2'd2) p = {1'b0, ~v[0]};
            BOOT_SWAP02: if (v == 2'd0) p = 2'd2;
                         else if (v == 2'd2) p = 2'd0;
            default:     p = v;
        endcase
        return p;
    endfunction : phys_of

    always_comb begin
        virtual_drive_selects = 4'h0;
        virtual_drive_selects[drv_num] = 1'b1;
        pins.sel = 4'h0;
        pins.mot = 4'h0;
        for (int i = 0; i < 4; i++) begin
            pins.sel[phys_of(2'(i), startup_drive_remap)] =
                virtual_drive_selects[i];
            pins.mot[phys_of(2'(i), startup_drive_remap)] =
                virtual_motor_enables[i];
        end
        // Compared on the virtual number; a choice of zero is excluded, so it never hits
        tape_mode = (tape_unit_choice != TAPE_NONE) &&
                    (tape_unit_choice == drv_num);
    end

endmodule : fdcpw_drive_map

// >>> sim/fdcpw_power_wake_properties.sv
`timescale 1ns/1ps
module fdcpw_power_wake_props
    import fdcpw_pkg::*;
#(
    parameter int MIN_PWRUP_CYC = MIN_PWRUP_CYC_DFLT
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire fdcpw_bus_t host_bus,
    input wire logic       osc_stop_pin,
    input wire logic       auto_pd_en,
    input wire logic       quiet_indicator_mask,
    input wire logic       flag_view,
    input wire logic       core_idle,
    input wire logic [7:0] core_msr,
    input wire logic [7:0] host_data_out_ff,
    input wire logic       host_data_oe_ff,
    input wire logic       int_cs_ff,
    input wire logic       irq_ff,
    input wire logic       idle_pin_ff,
    input wire logic       osc_stop_ff,
    input wire logic       core_rst_ff,
    input wire logic [7:0] cmd_byte_ff,
    input wire logic       cmd_valid_ff,
    input wire logic       auto_pd_ff,
    input wire logic       dsr_pd_ff,
    input wire fdcpw_drv_t drv_pins_ff,
    input wire logic       tape_mode_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Read data and its enable land on the same edge as the state change
    sequence s_msr_read;
        $rose(host_data_oe_ff) && host_bus.addr == OFS_MSR;
    endsequence
    sequence s_init_done;
        $fell(core_rst_ff);
    endsequence

    a_auto_reads_ready: assert property (
        s_msr_read ##0 $past(auto_pd_ff) |-> host_data_out_ff == MSR_READY)
        else $error("status not ready while asleep");
    a_read_starts_wake: assert property (
        s_msr_read ##0 $past(auto_pd_ff) |-> !auto_pd_ff)
        else $error("status read left the part asleep");
    a_dsr_keeps_rqm: assert property (
        s_msr_read ##0 dsr_pd_ff |-> host_data_out_ff[7])
        else $error("ready flag low in rate-select powerdown");
    a_idle_mask_low: assert property (
        quiet_indicator_mask [*4] |-> !idle_pin_ff)
        else $error("idle pin high while masked");
    a_idle_shows_pd: assert property (
        (auto_pd_ff && !quiet_indicator_mask) [*4] |-> idle_pin_ff)
        else $error("idle pin low while asleep");
    a_osc_stop_follows: assert property (
        osc_stop_pin [*4] |-> osc_stop_ff)
        else $error("oscillator not stopped by pin");
    a_no_select_idle: assert property (
        (host_bus.cs_n && host_bus.dack_n) [*5] |-> !int_cs_ff)
        else $error("internal select without select or acknowledge");
    a_dsr_exit_resets: assert property (
        $fell(dsr_pd_ff) |-> core_rst_ff)
        else $error("powerdown left without internal reset");
    a_init_then_irq: assert property (
        s_init_done |-> ##[0:2] irq_ff)
        else $error("no interrupt after initialisation");
    a_select_onehot: assert property (
        $onehot0(drv_pins_ff.sel))
        else $error("several drive selects active");
    // One edge after release the pins already show the cleared register
    a_rst_clears_dor: assert property (
        disable iff (1'h0) !reset_n |=>
            drv_pins_ff.mot == 4'h0 && drv_pins_ff.sel[3:1] == 3'h0)
        else $error("drive pins not cleared by reset");
endmodule : fdcpw_power_wake_props

bind fdcpw_power_wake fdcpw_power_wake_props #(
    .MIN_PWRUP_CYC(MIN_PWRUP_CYC)
) props_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .host_bus(host_bus),
    .osc_stop_pin(osc_stop_pin), .auto_pd_en(auto_pd_en),
    .quiet_indicator_mask(quiet_indicator_mask), .flag_view(flag_view),
    .core_idle(core_idle), .core_msr(core_msr),
    .host_data_out_ff(host_data_out_ff), .host_data_oe_ff(host_data_oe_ff),
    .int_cs_ff(int_cs_ff), .irq_ff(irq_ff), .idle_pin_ff(idle_pin_ff),
    .osc_stop_ff(osc_stop_ff), .core_rst_ff(core_rst_ff),
    .cmd_byte_ff(cmd_byte_ff), .cmd_valid_ff(cmd_valid_ff),
    .auto_pd_ff(auto_pd_ff), .dsr_pd_ff(dsr_pd_ff),
    .drv_pins_ff(drv_pins_ff), .tape_mode_ff(tape_mode_ff)
);

// >>> sim/fdcpw_host_model.sv
`timescale 1ns/1ps
module fdcpw_host_model
    import fdcpw_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] host_data_out_ff,
    output fdcpw_bus_t      host_bus
);
    initial host_bus = BUS_IDLE;

    // Select and address settle three clocks ahead of the strobe, which
    // stays low four clocks; the pins are slow, so no shortcut is taken
    task automatic access(
        input  logic [2:0] a,
        input  logic [7:0] wd,
        input  logic       wr,
        input  logic       dma,
        output logic [7:0] rd
    );
        host_bus.cs_n   <= dma;
        host_bus.dack_n <= !dma;
        host_bus.addr   <= a;
        host_bus.data   <= wd;
        repeat (3) @(posedge clk_sys);
        host_bus.rd_n <= wr;
        host_bus.wr_n <= !wr;
        repeat (4) @(posedge clk_sys);
        rd = host_data_out_ff;
        host_bus.rd_n <= 1'h1;
        host_bus.wr_n <= 1'h1;
        repeat (3) @(posedge clk_sys);
        // Released data lines show the inverse, never a stale byte
        host_bus.cs_n   <= 1'h1;
        host_bus.dack_n <= 1'h1;
        host_bus.data   <= ~wd;
        @(posedge clk_sys);
    endtask : access
endmodule : fdcpw_host_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import fdcpw_pkg::*;
    localparam int MIN_PW = 50;
    logic       clk_sys              = 1'h0;
    logic       reset_n              = 1'h0;
    logic       osc_stop_pin         = 1'h0;
    logic       auto_pd_en           = 1'h0;
    logic       quiet_indicator_mask = 1'h0;
    logic       flag_view            = 1'h0;
    logic       core_idle            = 1'h0;
    logic [7:0] core_msr             = 8'h10;
    logic       cs_seen              = 1'h0;
    int         n_mismatch           = 0;
    int         n_compared           = 0;
    logic [7:0] v;
    logic [1:0] t;
    logic [3:0] sv, mv;
    fdcpw_bus_t host_bus;
    fdcpw_drv_t drv_pins_ff;
    logic [7:0] host_data_out_ff, cmd_byte_ff;
    logic       host_data_oe_ff, int_cs_ff, irq_ff, idle_pin_ff, osc_stop_ff;
    logic       core_rst_ff, cmd_valid_ff, auto_pd_ff, dsr_pd_ff, tape_mode_ff;

    fdcpw_power_wake #(.MIN_PWRUP_CYC(MIN_PW)) fdcpw_power_wake_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .host_bus(host_bus),
        .osc_stop_pin(osc_stop_pin), .auto_pd_en(auto_pd_en),
        .quiet_indicator_mask(quiet_indicator_mask), .flag_view(flag_view),
        .core_idle(core_idle), .core_msr(core_msr),
        .host_data_out_ff(host_data_out_ff),
        .host_data_oe_ff(host_data_oe_ff), .int_cs_ff(int_cs_ff),
        .irq_ff(irq_ff), .idle_pin_ff(idle_pin_ff),
        .osc_stop_ff(osc_stop_ff), .core_rst_ff(core_rst_ff),
        .cmd_byte_ff(cmd_byte_ff), .cmd_valid_ff(cmd_valid_ff),
        .auto_pd_ff(auto_pd_ff), .dsr_pd_ff(dsr_pd_ff),
        .drv_pins_ff(drv_pins_ff), .tape_mode_ff(tape_mode_ff)
    );
    fdcpw_host_model fdcpw_host_model_i (
        .clk_sys(clk_sys), .host_data_out_ff(host_data_out_ff),
        .host_bus(host_bus)
    );

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (int_cs_ff) cs_seen <= 1'h1;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [2:0] a);
        fdcpw_host_model_i.access(a, 8'h00, 1'h0, 1'h0, v);
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        fdcpw_host_model_i.access(a, d, 1'h1, 1'h0, v);
    endtask : wr

    // A missed flag is not reported here; the following check catches it
    task automatic await(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk_sys);
            if (sel == 0 && irq_ff === 1'h1) break;
            if (sel == 1 && auto_pd_ff === 1'h1) break;
            if (sel == 2 && cmd_valid_ff === 1'h1) break;
        end
    endtask : await

    function automatic logic [3:0] rm(input int c, input logic [3:0] x);
        case (c)
            1: return {x[3], x[2], x[0], x[1]};
            2: return {x[3], x[0], x[1], x[2]};
            default: return x;
        endcase
    endfunction : rm

    task automatic close_out();
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        await(0, 400);
        check(8'(irq_ff), 8'h01);
        check(8'(core_rst_ff), 8'h00);
        check(drv_pins_ff, 8'h10);
        fdcpw_host_model_i.access(OFS_SRB, 8'h00, 1'h0, 1'h1, v);
        check(8'(cs_seen), 8'h00);
        wr(OFS_DOR, 8'h0C);
        fdcpw_host_model_i.access(OFS_SRB, 8'h00, 1'h0, 1'h1, v);
        check(8'(cs_seen), 8'h01);
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 4; d++) begin
                t = (c < 2) ? 2'(d) : 2'(d) ^ 2'h1;
                sv = 4'h1 << d;
                mv = 4'h9 ^ sv;
                wr(OFS_TDR, {4'h0, 2'(c), t});
                wr(OFS_DOR, {mv, 2'h1, 2'(d)});
                check(drv_pins_ff, {rm(c, sv), rm(c, mv)});
                check(8'(tape_mode_ff), 8'(t != 2'h0 && t == 2'(d)));
            end
        end
        wr(OFS_TDR, 8'h00);
        wr(OFS_DOR, 8'h04);
        osc_stop_pin <= 1'h1;
        repeat (6) @(posedge clk_sys);
        check(8'(osc_stop_ff), 8'h01);
        osc_stop_pin <= 1'h0;
        // Generous settling gap before the part is touched again
        repeat (200) @(posedge clk_sys);
        wr(OFS_FIFO, 8'hA5);
        wr(OFS_DSR, 8'h40);
        check(8'(dsr_pd_ff), 8'h01);
        rd(OFS_MSR);
        check(v & 8'h80, 8'h80);
        wr(OFS_DSR, 8'h80);
        check(8'(dsr_pd_ff), 8'h00);
        check(8'(core_rst_ff), 8'h01);
        await(0, 400);
        check(8'(irq_ff), 8'h01);
        wr(OFS_DSR, 8'h40);
        reset_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'h1;
        @(posedge clk_sys);
        check(8'(dsr_pd_ff), 8'h00);
        await(0, 400);
        core_idle <= 1'h1;
        auto_pd_en <= 1'h1;
        await(1, 400);
        rd(OFS_SRB);
        check(v & 8'hC0, 8'hC0);
        flag_view <= 1'h1;
        rd(OFS_DIR);
        check(v & 8'h06, 8'h06);
        flag_view <= 1'h0;
        check(8'(idle_pin_ff), 8'h01);
        quiet_indicator_mask <= 1'h1;
        repeat (5) @(posedge clk_sys);
        check(8'(idle_pin_ff), 8'h00);
        quiet_indicator_mask <= 1'h0;
        rd(OFS_MSR);
        check(v, MSR_READY);
        check(8'(auto_pd_ff), 8'h00);
        rd(OFS_MSR);
        check(v, MSR_READY);
        wr(OFS_FIFO, 8'h3C);
        rd(OFS_MSR);
        check(v, MSR_BUSY);
        await(2, 1400);
        check(cmd_byte_ff, 8'h3C);
        await(1, 400);
        rd(OFS_MSR);
        await(1, 1500);
        check(8'(auto_pd_ff), 8'h01);
        wr(OFS_FIFO, 8'h5A);
        rd(OFS_MSR);
        check(v, MSR_BUSY);
        await(2, 1400);
        check(cmd_byte_ff, 8'h5A);
        await(1, 400);
        wr(OFS_DOR, 8'h14);
        check(8'(auto_pd_ff), 8'h00);
        rd(OFS_MSR);
        check(v, MSR_READY);
        close_out();
    end
endmodule : tb_top
